// ---- src/reset_source_sequencer.sv ----
// Reset source sequencer: sources, release timing, straps, status and interrupt
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
module reset_source_sequencer
    import reset_seq_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic                  power_on_reset_in_n,
    input  wire logic                  input_clock_tick,
    input  wire logic                  reference_clock_tick,
    input  wire logic                  hard_reset_line_in,
    input  wire logic                  soft_reset_line_in,
    input  wire logic                  watchdog_expired,
    input  wire logic                  bus_monitor_expired,
    input  wire logic                  tap_reset_command,
    input  wire strap_type             strap_in,
    input  wire logic [DATA_WIDTH-1:0] hard_config_in,
    input  wire bus_req_type           bus_req,
    output logic [DATA_WIDTH-1:0]      bus_rdata,
    output line_drive_type             line_drive,
    output logic                       internal_por,
    output logic                       system_pll_locked,
    output logic                       core_reset_n,
    output strap_type                  strap_latched,
    output logic [DATA_WIDTH-1:0]      hard_config_word,
    output logic                       irq
);

    typedef struct packed {
        logic                    por_meta;
        logic                    por_sync;
        logic                    hard_meta;
        logic                    hard_sync;
        logic                    soft_meta;
        logic                    soft_sync;

        seq_state_type           seq;
        logic [COUNT_WIDTH-1:0]  count;
        logic [REF_DIV_WIDTH-1:0] div_count;

        logic                    int_por;
        logic                    pll_locked;
        logic                    hard_oe;
        logic                    soft_oe;
        logic                    core_rst_n;

        strap_type               straps;
        logic [DATA_WIDTH-1:0]   config_word;

        logic                    bus_mon_en;
        logic [REF_DIV_WIDTH-1:0] ref_div;

        logic [CAUSE_WIDTH-1:0]  cause;
        logic [CAUSE_WIDTH-1:0]  irq_status;
        logic [CAUSE_WIDTH-1:0]  irq_mask;
        logic                    irq;

        logic [DATA_WIDTH-1:0]   rdata;
    } state_type;

    localparam logic [COUNT_WIDTH-1:0] POR_STRETCH_LAST =
        COUNT_WIDTH'(POR_STRETCH_PERIODS - 1);
    localparam logic [COUNT_WIDTH-1:0] PLL_LOCK_LAST =
        COUNT_WIDTH'(PLL_LOCK_PERIODS - 1);
    localparam logic [COUNT_WIDTH-1:0] HARD_RELEASE_LAST =
        COUNT_WIDTH'(HARD_RELEASE_PERIODS - 1);
    localparam logic [COUNT_WIDTH-1:0] SOFT_RELEASE_LAST =
        COUNT_WIDTH'(SOFT_RELEASE_PERIODS - 1);
    localparam logic [COUNT_WIDTH-1:0] SOFT_ONLY_LAST =
        COUNT_WIDTH'(SOFT_ONLY_PERIODS - 1);

    localparam logic [COUNT_WIDTH-1:0] SETTLE_DONE = COUNT_WIDTH'(LINE_SETTLE_CYCLES);

    state_type s;
    state_type next_s;

    logic [CAUSE_WIDTH-1:0] hard_src;
    logic [CAUSE_WIDTH-1:0] soft_src;

    logic [CAUSE_WIDTH-1:0] irq_set;
    logic [CAUSE_WIDTH-1:0] irq_clear;
    logic                   lines_settled;
    logic                   ref_div_wrap;

    always_comb begin
        next_s = s;

        hard_src = '0;
        soft_src = '0;
        irq_set = '0;
        irq_clear = '0;
        lines_settled = (s.count == SETTLE_DONE);
        ref_div_wrap = ({1'b0, s.div_count} + 5'h01) >= {1'b0, s.ref_div};

        // First stage feeds only the second stage
        next_s.por_meta = power_on_reset_in_n;
        next_s.por_sync = s.por_meta;
        next_s.hard_meta = hard_reset_line_in;
        next_s.hard_sync = s.hard_meta;
        next_s.soft_meta = soft_reset_line_in;
        next_s.soft_sync = s.soft_meta;

        // Straps follow the pin while power-on reset is low, frozen at release
        if (!power_on_reset_in_n) begin
            next_s.straps = strap_in;
        end

        // Line sources only count while the lines are ours to watch
        hard_src[CAUSE_WATCHDOG] = watchdog_expired && s.straps.watchdog_enable_strap;
        hard_src[CAUSE_BUS_MON] = bus_monitor_expired && s.bus_mon_en;
        hard_src[CAUSE_EXT_HARD] = !s.hard_oe && !s.hard_sync && lines_settled;
        soft_src[CAUSE_TAP] = tap_reset_command;
        soft_src[CAUSE_EXT_SOFT] = !s.soft_oe && !s.soft_sync && lines_settled;

        if (!s.por_sync) begin
            // Set each cycle so a clear cannot hide it
            next_s.cause = CAUSE_WIDTH'(1) << CAUSE_POR;
            irq_set[CAUSE_POR] = 1'b1;
            next_s.seq = POR_HOLD;
            next_s.count = '0;
            next_s.div_count = '0;
            next_s.int_por = 1'b1;
            next_s.pll_locked = 1'b0;
            next_s.hard_oe = 1'b1;
            next_s.soft_oe = 1'b1;
            next_s.core_rst_n = 1'b0;
        end else begin
            case (s.seq)
                POR_HOLD: begin
                    next_s.seq = POR_STRETCH;
                    next_s.count = '0;
                end

                POR_STRETCH: begin
                    if (input_clock_tick) begin
                        next_s.count = s.count + 1'b1;
                        if (s.count == POR_STRETCH_LAST) begin
                            next_s.int_por = 1'b0;
                            next_s.config_word = hard_config_in;
                            next_s.seq = PLL_WAIT;
                            next_s.count = '0;
                            next_s.div_count = '0;
                        end
                    end
                end

                PLL_WAIT: begin
                    // PLL reference is the input clock over the divide factor
                    if (input_clock_tick) begin
                        next_s.div_count = s.div_count + 1'b1;
                        if (ref_div_wrap) begin
                            next_s.div_count = '0;
                            next_s.count = s.count + 1'b1;
                            if (s.count == PLL_LOCK_LAST) begin
                                next_s.pll_locked = 1'b1;
                                next_s.seq = HARD_HOLD;
                                next_s.count = '0;
                            end
                        end
                    end
                end

                HARD_HOLD: begin
                    if (reference_clock_tick) begin
                        next_s.count = s.count + 1'b1;
                        if (s.count == HARD_RELEASE_LAST) begin
                            next_s.hard_oe = 1'b0;
                        end
                        // Soft trails hard by three ticks
                        if (s.count == SOFT_RELEASE_LAST) begin
                            next_s.soft_oe = 1'b0;
                            next_s.core_rst_n = 1'b1;
                            next_s.seq = RUN;
                            next_s.count = '0;
                        end
                    end
                end

                SOFT_HOLD: begin
                    // Cores only; straps and config kept
                    if (reference_clock_tick) begin
                        next_s.count = s.count + 1'b1;
                        if (s.count == SOFT_ONLY_LAST) begin
                            next_s.soft_oe = 1'b0;
                            next_s.core_rst_n = 1'b1;
                            next_s.seq = RUN;
                            next_s.count = '0;
                        end
                    end
                end

                RUN: begin
                    // Released lines need a few cycles to read high through the sync
                    if (!lines_settled) begin
                        next_s.count = s.count + 1'b1;
                    end
                end

                default: begin
                    next_s.seq = POR_HOLD;
                end
            endcase

            // Hard sources win over soft ones and may escalate a soft reset
            if ((s.seq == RUN || s.seq == SOFT_HOLD) && (hard_src != '0)) begin
                next_s.seq = HARD_HOLD;
                next_s.count = '0;
                next_s.hard_oe = 1'b1;
                next_s.soft_oe = 1'b1;
                next_s.core_rst_n = 1'b0;
                next_s.config_word = hard_config_in;
                next_s.cause = hard_src;
                irq_set = hard_src;
            end else if (s.seq == RUN && soft_src != '0) begin
                // Soft requests only from idle
                next_s.seq = SOFT_HOLD;
                next_s.count = '0;
                next_s.soft_oe = 1'b1;
                next_s.core_rst_n = 1'b0;
                next_s.cause = soft_src;
                irq_set = soft_src;
            end
        end

        // Register writes
        if (bus_req.write) begin
            case (bus_req.addr)
                CONTROL_OFFSET: begin
                    next_s.bus_mon_en = bus_req.wdata[CTRL_BUS_MON_EN_BIT];
                    next_s.ref_div =
                        bus_req.wdata[CTRL_REF_DIV_LSB +: REF_DIV_WIDTH];
                end

                IRQ_STATUS_OFFSET: begin
                    irq_clear = bus_req.wdata[CAUSE_WIDTH-1:0];
                end

                IRQ_MASK_OFFSET: begin
                    next_s.irq_mask = bus_req.wdata[CAUSE_WIDTH-1:0];
                end

                default: begin
                end
            endcase
        end

        // A new event beats a write-one clear in the same cycle
        next_s.irq_status = (s.irq_status & ~irq_clear) | irq_set;
        next_s.irq = |(next_s.irq_status & next_s.irq_mask);

        // Read data stands one cycle only; unmapped reads return zero
        next_s.rdata = '0;
        if (bus_req.read) begin
            case (bus_req.addr)
                CONTROL_OFFSET: begin
                    next_s.rdata[CTRL_BUS_MON_EN_BIT] = s.bus_mon_en;
                    next_s.rdata[CTRL_REF_DIV_LSB +: REF_DIV_WIDTH] = s.ref_div;
                end

                CAUSE_OFFSET: begin
                    next_s.rdata[CAUSE_WIDTH-1:0] = s.cause;
                end

                STRAP_OFFSET: begin
                    next_s.rdata[$bits(strap_type)-1:0] = s.straps;
                end

                CONFIG_OFFSET: begin
                    next_s.rdata = s.config_word;
                end

                IRQ_STATUS_OFFSET: begin
                    next_s.rdata[CAUSE_WIDTH-1:0] = s.irq_status;
                end

                IRQ_MASK_OFFSET: begin
                    next_s.rdata[CAUSE_WIDTH-1:0] = s.irq_mask;
                end

                STATE_OFFSET: begin
                    next_s.rdata[2:0] = s.seq;
                    next_s.rdata[4] = s.int_por;
                    next_s.rdata[5] = s.pll_locked;
                    next_s.rdata[6] = s.hard_oe;
                    next_s.rdata[7] = s.soft_oe;
                    next_s.rdata[8] = s.core_rst_n;
                end

                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s.por_meta <= 1'b0;
            s.por_sync <= 1'b0;
            s.hard_meta <= 1'b1;
            s.hard_sync <= 1'b1;
            s.soft_meta <= 1'b1;
            s.soft_sync <= 1'b1;

            s.seq <= POR_HOLD;
            s.count <= '0;
            s.div_count <= '0;

            s.int_por <= 1'b1;
            s.pll_locked <= 1'b0;
            s.hard_oe <= 1'b1;
            s.soft_oe <= 1'b1;
            s.core_rst_n <= 1'b0;

            s.straps <= STRAP_RESET;
            s.config_word <= '0;

            s.bus_mon_en <= 1'b0;
            s.ref_div <= REF_DIV_RESET;

            s.cause <= '0;
            s.irq_status <= '0;
            s.irq_mask <= '0;
            s.irq <= 1'b0;

            s.rdata <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Open-drain: the lines are only ever pulled low
    assign line_drive.hard_out = 1'b0;
    assign line_drive.soft_out = 1'b0;
    assign line_drive.hard_oe = s.hard_oe;
    assign line_drive.soft_oe = s.soft_oe;

    assign bus_rdata = s.rdata;
    assign internal_por = s.int_por;
    assign system_pll_locked = s.pll_locked;
    assign core_reset_n = s.core_rst_n;

    assign strap_latched = s.straps;
    assign hard_config_word = s.config_word;
    assign irq = s.irq;

endmodule

// ---- src/reset_seq_pkg.sv ----
// Constants, types and register map of the reset source sequencer
package reset_seq_pkg;

    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;
    localparam int COUNT_WIDTH = 13;
    localparam int CAUSE_WIDTH = 6;

    // Sequence lengths in periods of the named clock
    localparam int POR_MIN_INPUT_PERIODS = 16;
    localparam int POR_STRETCH_PERIODS = 1024;
    localparam int PLL_LOCK_PERIODS = 6400;
    localparam int HARD_RELEASE_PERIODS = 512;
    localparam int SOFT_RELEASE_PERIODS = 515;
    localparam int SOFT_ONLY_PERIODS = 512;
    localparam int LINE_SETTLE_CYCLES = 4;

    // Register byte offsets
    localparam logic [ADDR_WIDTH-1:0] CONTROL_OFFSET = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] CAUSE_OFFSET = 8'h04;
    localparam logic [ADDR_WIDTH-1:0] STRAP_OFFSET = 8'h08;
    localparam logic [ADDR_WIDTH-1:0] CONFIG_OFFSET = 8'h0C;
    localparam logic [ADDR_WIDTH-1:0] IRQ_STATUS_OFFSET = 8'h10;
    localparam logic [ADDR_WIDTH-1:0] IRQ_MASK_OFFSET = 8'h14;
    localparam logic [ADDR_WIDTH-1:0] STATE_OFFSET = 8'h18;

    // Control fields
    localparam int CTRL_BUS_MON_EN_BIT = 0;
    localparam int CTRL_REF_DIV_LSB = 4;
    localparam int REF_DIV_WIDTH = 4;
    localparam logic [REF_DIV_WIDTH-1:0] REF_DIV_RESET = 4'h1;

    // Cause and interrupt bit positions
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_EXT_HARD = 1;
    localparam int CAUSE_EXT_SOFT = 2;
    localparam int CAUSE_WATCHDOG = 3;
    localparam int CAUSE_BUS_MON = 4;
    localparam int CAUSE_TAP = 5;

    typedef enum logic [2:0] {
        POR_HOLD,
        POR_STRETCH,
        PLL_WAIT,
        HARD_HOLD,
        SOFT_HOLD,
        RUN
    } seq_state_type;

    typedef struct packed {
        logic       reset_config_select;
        logic       config_source_select;
        logic       slave_port_sync_select;
        logic       slave_port_wide_select;
        logic [3:0] chip_identifier_straps;
        logic [2:0] boot_mode_straps;
        logic       watchdog_enable_strap;
        logic [1:0] clock_mode_straps;
    } strap_type;

    localparam strap_type STRAP_RESET = '0;

    typedef struct packed {
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
        logic                  write;
        logic                  read;
    } bus_req_type;

    typedef struct packed {
        logic hard_out;
        logic hard_oe;
        logic soft_out;
        logic soft_oe;
    } line_drive_type;

endpackage

// ---- testbench/reset_seq_checker_sva.sv ----
// Assertion checker on the reset source sequencer ports
`timescale 1ns/10ps
module reset_seq_checker
    import reset_seq_pkg::*;
(
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    input wire logic                  power_on_reset_in_n,
    input wire logic                  watchdog_expired,
    input wire logic                  bus_monitor_expired,
    input wire logic                  tap_reset_command,
    input wire line_drive_type        line_drive,
    input wire logic                  internal_por,
    input wire logic                  system_pll_locked,
    input wire logic                  core_reset_n,
    input wire strap_type             strap_latched
);
    // Lengths assume one tick per core cycle, as the bench drives them
    logic [12:0] stretch_cnt;
    logic [12:0] lock_cnt;
    logic [12:0] hold_cnt;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stretch_cnt <= '0;
            lock_cnt    <= '0;
            hold_cnt    <= '0;
        end else begin
            stretch_cnt <= power_on_reset_in_n ? stretch_cnt + 13'(internal_por) : '0;
            lock_cnt    <= internal_por ? '0 : lock_cnt + 13'(!system_pll_locked);
            hold_cnt    <= (line_drive.hard_oe && system_pll_locked) ? hold_cnt + 13'h1 : '0;
        end
    end
    property p_open_drain;
        !line_drive.hard_out && !line_drive.soft_out;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("line driven high");
    property p_hard_with_soft;
        line_drive.hard_oe |-> line_drive.soft_oe;
    endproperty
    a_hard_with_soft: assert property (p_hard_with_soft)
        else $error("hard without soft");
    property p_por_all;
        internal_por |-> line_drive.hard_oe && line_drive.soft_oe && !core_reset_n
            && !system_pll_locked;
    endproperty
    a_por_all: assert property (p_por_all)
        else $error("power-on reset incomplete");
    property p_stretch;
        $fell(internal_por) |-> stretch_cnt inside {[1024:1032]};
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("stretch length wrong");
    property p_lock;
        $rose(system_pll_locked) |-> lock_cnt inside {[6400:6404]};
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock time wrong");
    property p_hard_len;
        $fell(line_drive.hard_oe) |-> hold_cnt inside {[511:514]};
    endproperty
    a_hard_len: assert property (p_hard_len)
        else $error("hard hold length wrong");
    property p_soft_after;
        $fell(line_drive.hard_oe) |-> line_drive.soft_oe [*3] ##1 !line_drive.soft_oe;
    endproperty
    a_soft_after: assert property (p_soft_after)
        else $error("soft release not three later");
    property p_straps_kept;
        !internal_por && !$past(internal_por) |-> $stable(strap_latched);
    endproperty
    a_straps_kept: assert property (p_straps_kept)
        else $error("straps changed");
    property p_watchdog;
        watchdog_expired && strap_latched.watchdog_enable_strap && core_reset_n
            |=> line_drive.hard_oe && !core_reset_n;
    endproperty
    a_watchdog: assert property (p_watchdog)
        else $error("watchdog ignored");
    property p_tap;
        tap_reset_command && core_reset_n && !watchdog_expired && !bus_monitor_expired
            |=> line_drive.soft_oe && !core_reset_n;
    endproperty
    a_tap: assert property (p_tap)
        else $error("tap command ignored");
endmodule
bind reset_source_sequencer reset_seq_checker u_checker (
    .core_clk           (core_clk),
    .rst_n              (rst_n),
    .power_on_reset_in_n(power_on_reset_in_n),
    .watchdog_expired   (watchdog_expired),
    .bus_monitor_expired(bus_monitor_expired),
    .tap_reset_command  (tap_reset_command),
    .line_drive         (line_drive),
    .internal_por       (internal_por),
    .system_pll_locked  (system_pll_locked),
    .core_reset_n       (core_reset_n),
    .strap_latched      (strap_latched)
);

// ---- testbench/board_supervisor.sv ----
// Board reset supervisor, strap resistors and pulled-up reset wires
`timescale 1ns/10ps
module board_supervisor
    import reset_seq_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           por_request,
    input  wire strap_type      strap_value,
    input  wire line_drive_type line_drive,
    input  wire logic           pull_hard,
    input  wire logic           pull_soft,
    output logic                power_on_reset_in_n,
    output strap_type           strap_in,
    output logic                hard_reset_line_in,
    output logic                soft_reset_line_in
);
    int hold_cnt = 0;
    always @(posedge core_clk) begin
        if (por_request) begin
            hold_cnt <= 0;
        end else if (hold_cnt < 40) begin
            hold_cnt <= hold_cnt + 1;
        end
    end
    // Low 20 cycles after the request, above the minimum of 16
    assign power_on_reset_in_n = (hold_cnt >= 20);
    // Held 4 cycles past release, then inverted so late sampling shows
    assign strap_in = (hold_cnt < 24) ? strap_value : ~strap_value;
    // Pull-ups on both wires; every party only pulls low
    assign hard_reset_line_in = !(line_drive.hard_oe || pull_hard);
    assign soft_reset_line_in = !(line_drive.soft_oe || pull_soft);
endmodule

// ---- testbench/reset_source_sequencer_test.sv ----
// Self-checking bench: power-on sequence, registers, then each reset source
`timescale 1ns/10ps
module reset_source_sequencer_test
    import reset_seq_pkg::*;
;
    logic                  core_clk, rst_n, por_request, pull_hard, pull_soft, hard, irq;
    logic                  watchdog_expired, bus_monitor_expired, tap_reset_command;
    logic                  power_on_reset_in_n, hard_reset_line_in, soft_reset_line_in;
    logic                  internal_por, system_pll_locked, core_reset_n;
    strap_type             strap_value, strap_in, strap_latched;
    logic [DATA_WIDTH-1:0] hard_config_in, hard_config_word, bus_rdata, rd, exp_cfg;
    bus_req_type           bus_req;
    line_drive_type        line_drive;
    int                    error_cnt, n_checks, seed, t0, t1;
    int                    cyc = 0;
    int                    plan[$] = '{CAUSE_BUS_MON, CAUSE_WATCHDOG, CAUSE_TAP,
                                       CAUSE_EXT_SOFT, CAUSE_EXT_HARD};
    reset_source_sequencer DUT (
        .core_clk(core_clk), .rst_n(rst_n), .power_on_reset_in_n(power_on_reset_in_n),
        .input_clock_tick(1'b1), .reference_clock_tick(1'b1),
        .hard_reset_line_in(hard_reset_line_in), .soft_reset_line_in(soft_reset_line_in),
        .watchdog_expired(watchdog_expired), .bus_monitor_expired(bus_monitor_expired),
        .tap_reset_command(tap_reset_command), .strap_in(strap_in),
        .hard_config_in(hard_config_in), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .line_drive(line_drive), .internal_por(internal_por),
        .system_pll_locked(system_pll_locked), .core_reset_n(core_reset_n),
        .strap_latched(strap_latched), .hard_config_word(hard_config_word), .irq(irq));
    board_supervisor partner (
        .core_clk(core_clk), .por_request(por_request), .strap_value(strap_value),
        .line_drive(line_drive), .pull_hard(pull_hard), .pull_soft(pull_soft),
        .power_on_reset_in_n(power_on_reset_in_n), .strap_in(strap_in),
        .hard_reset_line_in(hard_reset_line_in), .soft_reset_line_in(soft_reset_line_in));
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    function automatic logic probe(input int which);
        case (which)
            0: return internal_por;
            1: return system_pll_locked;
            2: return line_drive.hard_oe;
            3: return line_drive.soft_oe;
            4: return core_reset_n;
            default: return power_on_reset_in_n;
        endcase
    endfunction
    task automatic wait_for(input int which, input logic level, input int limit);
        int n;
        n = 0;
        while (probe(which) !== level) begin
            @(posedge core_clk);
            #1;
            n++;
            if (n > limit) begin
                check(32'(probe(which)), 32'(level));
                end_of_test();
            end
        end
    endtask
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge core_clk);
        bus_req <= '0;
    endtask
    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: '0, write: 1'b0, read: 1'b1};
        @(posedge core_clk);
        bus_req <= '0;
        #1;
        d = bus_rdata;
    endtask
    // Pending event raises the line, a one-to-clear write drops it
    task automatic irq_clear();
        @(posedge core_clk);
        #1;
        check(32'(irq), 32'h1);
        bus_write(IRQ_STATUS_OFFSET, 32'h0000_003f);
        @(posedge core_clk);
        #1;
        check(32'(irq), 32'h0);
    endtask
    initial begin
        {core_clk, rst_n, pull_hard, pull_soft, error_cnt, n_checks} = '0;
        {watchdog_expired, bus_monitor_expired, tap_reset_command, bus_req} = '0;
        por_request = 1'b1;
        seed = 32'h0000_e24f;
        strap_value = strap_type'($random(seed));
        strap_value.watchdog_enable_strap = 1'b1;
        hard_config_in = $random(seed);
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        por_request <= 1'b0;
        wait_for(5, 1'b1, 60);
        t0 = cyc;
        wait_for(0, 1'b0, 1200);
        check(32'(cyc - t0 >= 1024 && cyc - t0 <= 1032), 32'h1);
        check(32'(strap_latched), 32'(strap_value));
        t0 = cyc;
        wait_for(1, 1'b1, 6500);
        check(32'(cyc - t0 >= 6400 && cyc - t0 <= 6404), 32'h1);
        t0 = cyc;
        wait_for(2, 1'b0, 600);
        check(32'(cyc - t0 >= 511 && cyc - t0 <= 514), 32'h1);
        t0 = cyc;
        wait_for(3, 1'b0, 8);
        check(cyc - t0, 32'h3);
        exp_cfg = hard_config_in;
        check(hard_config_word, exp_cfg);
        bus_read(STATE_OFFSET, rd);
        check(rd, 32'h0000_0125);
        bus_read(STRAP_OFFSET, rd);
        check(rd, 32'(strap_value));
        bus_write(CAUSE_OFFSET, 32'hffff_ffff);
        bus_read(CAUSE_OFFSET, rd);
        check(rd, 32'h1);
        bus_read(8'h40, rd);
        check(rd, 32'h0);
        check(32'(irq), 32'h0);
        bus_write(IRQ_MASK_OFFSET, 32'h0000_003f);
        irq_clear();
        // Monitor expiry while disabled must be ignored
        @(posedge core_clk);
        bus_monitor_expired <= 1'b1;
        @(posedge core_clk);
        bus_monitor_expired <= 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
        check(32'(core_reset_n), 32'h1);
        bus_write(CONTROL_OFFSET, 32'h0000_0011);
        bus_read(CONTROL_OFFSET, rd);
        check(rd, 32'h0000_0011);
        foreach (plan[i]) begin
            repeat (12) @(posedge core_clk);
            hard_config_in <= $random(seed);
            hard = plan[i] inside {CAUSE_WATCHDOG, CAUSE_BUS_MON, CAUSE_EXT_HARD};
            @(posedge core_clk);
            case (plan[i])
                CAUSE_WATCHDOG: watchdog_expired <= 1'b1;
                CAUSE_BUS_MON: bus_monitor_expired <= 1'b1;
                CAUSE_TAP: tap_reset_command <= 1'b1;
                CAUSE_EXT_HARD: pull_hard <= 1'b1;
                default: pull_soft <= 1'b1;
            endcase
            @(posedge core_clk);
            {watchdog_expired, bus_monitor_expired, tap_reset_command} <= '0;
            #1;
            wait_for(4, 1'b0, 8);
            t0 = cyc;
            check(32'(line_drive.soft_oe), 32'h1);
            check(32'(line_drive.hard_oe), 32'(hard));
            // Board pulls soft low while the device holds reset: not a new cause
            @(posedge core_clk);
            pull_soft <= 1'b1;
            repeat (20) @(posedge core_clk);
            {pull_hard, pull_soft} <= '0;
            #1;
            wait_for(2, 1'b0, 600);
            t1 = cyc;
            wait_for(3, 1'b0, 600);
            if (hard) begin
                check(32'(t1 - t0 >= 511 && t1 - t0 <= 514), 32'h1);
                check(cyc - t1, 32'h3);
                exp_cfg = hard_config_in;
            end else begin
                check(32'(cyc - t0 >= 511 && cyc - t0 <= 514), 32'h1);
            end
            check(32'(core_reset_n), 32'h1);
            check(hard_config_word, exp_cfg);
            check(32'(strap_latched), 32'(strap_value));
            bus_read(CAUSE_OFFSET, rd);
            check(rd, 32'h1 << plan[i]);
            irq_clear();
        end
        end_of_test();
    end
endmodule
